// ### hw/sram_capture_pkg.sv
package sram_capture_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W      = 20;
   localparam int LANES       = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W      = LANE_DATA_W + 1;
   localparam int BURST_W     = 2;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int BURST_LSB   = 0;
   localparam int PARITY_POS  = LANE_DATA_W;
   localparam logic [ADDR_W-1:0]  ADDR_RST  = 20'h00000;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [LANES-1:0]   LANE_NONE = 4'h0;
   localparam logic [LANES-1:0]   LANE_ALL  = 4'hf;
   localparam logic               CAP_RST   = 1'h0;
   localparam logic [LANES*LANE_W-1:0] MASK_RST = 36'h0;
   localparam logic [LANES*LANE_W-1:0] DATA_RST = 36'h0;

   // ****************************************
   // access kinds
   // ****************************************
   typedef enum logic [1:0]
   {
      ACC_IDLE  = 2'b00,
      ACC_READ  = 2'b01,
      ACC_WRITE = 2'b10
   } access_t;

endpackage

// ### hw/write_qual_if.sv
`timescale 1ns/1ps
`default_nettype none
interface write_qual_if;
   import sram_capture_pkg::*;
   logic                 all_lanes_write_n;
   logic                 lane_write_enable_n;
   logic [LANES-1:0]     lane_write_sel_n;
   logic [LANES-1:0]     lane_wr;
   logic                 any_wr;
   modport ctl  (output all_lanes_write_n, output lane_write_enable_n, output lane_write_sel_n,
                 input lane_wr, input any_wr);
   modport qual (input all_lanes_write_n, input lane_write_enable_n, input lane_write_sel_n,
                 output lane_wr, output any_wr);
endinterface
`default_nettype wire

// ### hw/lane_write_qual.sv
`timescale 1ns/1ps
`default_nettype none
module lane_write_qual
   import sram_capture_pkg::*;
(
   write_qual_if.qual wq
);
   // ****************************************
   // lane qualification
   // ****************************************
   wire              global_wr;
   wire              byte_wr_ok;
   wire [LANES-1:0]  byte_lanes;

   assign global_wr  = ~wq.all_lanes_write_n;
   assign byte_wr_ok = ~wq.lane_write_enable_n;
   assign byte_lanes = byte_wr_ok ? ~wq.lane_write_sel_n : LANE_NONE;
   assign wq.lane_wr = global_wr ? LANE_ALL : byte_lanes;
   assign wq.any_wr  = |wq.lane_wr;
endmodule
`default_nettype wire

// ### hw/sync_sram_addr_write_capture.sv
`timescale 1ns/1ps
`default_nettype none
module sync_sram_addr_write_capture
   import sram_capture_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   input  wire logic [ADDR_W-1:0]           addr_in,
   input  wire logic                        processor_addr_strobe_n,
   input  wire logic                        controller_addr_strobe_n,
   input  wire logic                        chip_select_first_n,
   input  wire logic                        chip_select_second,
   input  wire logic                        chip_select_third_n,
   input  wire logic [LANES-1:0]            lane_write_sel_n,
   input  wire logic                        lane_write_enable_n,
   input  wire logic                        all_lanes_write_n,
   input  wire logic [LANES*LANE_W-1:0]     wr_data_in,
   output logic [ADDR_W-1:0]                addr_q,
   output logic [BURST_W-1:0]               burst_count_q,
   output logic                             capture_q,
   output logic [1:0]                       access_q,
   output logic [LANES*LANE_W-1:0]          bit_write_mask_q,
   output logic [LANES*LANE_W-1:0]          wr_data_q
);
   // ****************************************
   // pin levels
   // ****************************************
   // every strobe and chip-select pin gets an active-high name once, so the decode below reads
   // as the rules are worded and no polarity slip hides in a long expression
   wire proc_strobe_low;
   wire ctrl_strobe_low;
   wire first_sel_low;
   wire second_sel_high;
   wire third_sel_low;

   assign proc_strobe_low = ~processor_addr_strobe_n;
   assign ctrl_strobe_low = ~controller_addr_strobe_n;
   assign first_sel_low   = ~chip_select_first_n;
   assign second_sel_high = chip_select_second;
   assign third_sel_low   = ~chip_select_third_n;

   // ****************************************
   // strobe and select decode
   // ****************************************
   // a high first select masks both strobes, through the processor gate and the select decode; with both strobes low the
   // controller strobe is dropped, so that edge captures as a processor-strobe read
   wire selects_active;
   wire proc_strobe_ok;
   wire ctrl_strobe_ok;
   wire capture;
   wire write_strobe_ok;

   assign selects_active  = first_sel_low & second_sel_high & third_sel_low;
   assign proc_strobe_ok  = proc_strobe_low & first_sel_low;
   assign ctrl_strobe_ok  = ctrl_strobe_low & ~proc_strobe_low;
   assign capture         = (proc_strobe_ok | ctrl_strobe_ok) & selects_active;
   // a processor-strobe start is always a read; writes are qualified only with the controller strobe
   assign write_strobe_ok = ctrl_strobe_ok;

   // ****************************************
   // lane qualification
   // ****************************************
   write_qual_if wq ();
   assign wq.all_lanes_write_n   = all_lanes_write_n;
   assign wq.lane_write_enable_n = lane_write_enable_n;
   assign wq.lane_write_sel_n    = lane_write_sel_n;

   lane_write_qual u_qual
   (
      .wq (wq)
   );

   // ****************************************
   // lane mask
   // ****************************************
   // widen one bit per lane to the data byte and its parity bit; the parity bit goes
   // with its byte so a partial write never leaves a stale parity behind
   function automatic logic [LANES*LANE_W-1:0] lane_mask(input logic [LANES-1:0] lanes);
      logic [LANES*LANE_W-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++)
      begin
         m[i*LANE_W +: LANE_DATA_W] = {LANE_DATA_W{lanes[i]}};
         m[i*LANE_W + PARITY_POS]   = lanes[i];
      end
      return m;
   endfunction

   // ****************************************
   // access kind
   // ****************************************
   wire                      is_write;
   wire                      is_read;
   wire [LANES-1:0]          lanes_eff;
   wire [1:0]                nxt_access;
   wire [LANES*LANE_W-1:0]   nxt_mask;

   assign is_write   = capture & write_strobe_ok & wq.any_wr;
   assign is_read    = capture & ~is_write;
   assign lanes_eff  = is_write ? wq.lane_wr : LANE_NONE;
   assign nxt_access = is_write ? ACC_WRITE : (is_read ? ACC_READ : ACC_IDLE);
   assign nxt_mask   = lane_mask(lanes_eff);

   // ****************************************
   // registers
   // ****************************************
   logic [ADDR_W-1:0]          addr_ff;
   logic [BURST_W-1:0]         burst_ff;
   logic                       capture_ff;
   logic [1:0]                 access_ff;
   logic [LANES*LANE_W-1:0]    mask_ff;
   logic [LANES*LANE_W-1:0]    data_ff;

   // ****************************************
   // next values
   // ****************************************
   // the address and burst registers hold between captures; the data register samples wr_data_in
   // on every clock, capture or not; everything else is a one-cycle report of the edge just taken
   wire [ADDR_W-1:0]           nxt_addr;
   wire [BURST_W-1:0]          nxt_burst;
   wire                        nxt_capture;
   wire [LANES*LANE_W-1:0]     nxt_data;

   assign nxt_addr    = capture ? addr_in : addr_ff;
   assign nxt_burst   = capture ? addr_in[BURST_LSB +: BURST_W] : burst_ff;
   assign nxt_capture = capture;
   assign nxt_data    = wr_data_in;

   // ****************************************
   // flops
   // ****************************************
   // one short block per register keeps each reset value beside its register
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         addr_ff <= ADDR_RST;
      end
      else
      begin
         addr_ff <= nxt_addr;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         burst_ff <= BURST_RST;
      end
      else
      begin
         burst_ff <= nxt_burst;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         capture_ff <= CAP_RST;
      end
      else
      begin
         capture_ff <= nxt_capture;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         access_ff <= ACC_IDLE;
      end
      else
      begin
         access_ff <= nxt_access;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         mask_ff <= MASK_RST;
      end
      else
      begin
         mask_ff <= nxt_mask;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         data_ff <= DATA_RST;
      end
      else
      begin
         data_ff <= nxt_data;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign addr_q           = addr_ff;
   assign burst_count_q    = burst_ff;
   assign capture_q        = capture_ff;
   assign access_q         = access_ff;
   assign bit_write_mask_q = mask_ff;
   assign wr_data_q        = data_ff;
endmodule
`default_nettype wire

// ### verification/sram_cap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sram_cap_asserts
   import sram_capture_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic [LANES-1:0] lane_write_sel_n,
   input wire logic lane_write_enable_n,
   input wire logic all_lanes_write_n,
   input wire logic [LANES*LANE_W-1:0] wr_data_in,
   input wire logic [ADDR_W-1:0] addr_q,
   input wire logic [BURST_W-1:0] burst_count_q,
   input wire logic capture_q,
   input wire logic [1:0] access_q,
   input wire logic [LANES*LANE_W-1:0] bit_write_mask_q,
   input wire logic [LANES*LANE_W-1:0] wr_data_q
);
   wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   wire take = sel && !(processor_addr_strobe_n && controller_addr_strobe_n);
   wire wr = take && processor_addr_strobe_n;
   wire [3:0] ln = !all_lanes_write_n ? LANE_ALL : lane_write_enable_n ? LANE_NONE : ~lane_write_sel_n;
   wire [35:0] msk = {{9{ln[3]}}, {9{ln[2]}}, {9{ln[1]}}, {9{ln[0]}}};
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_addr_capture: assert property (take |=> capture_q && addr_q == $past(addr_in)) else $error("no capture");
   a_idle_hold: assert property (!take |=> !capture_q && $stable(addr_q) && access_q == ACC_IDLE) else $error("idle");
   a_burst_load: assert property (take |=> burst_count_q == $past(addr_in[1:0])) else $error("burst");
   a_lane_mask: assert property (wr && |ln |=> access_q == ACC_WRITE && bit_write_mask_q == $past(msk)) else $error("mask");
   a_global_write: assert property (wr && !all_lanes_write_n |=> &bit_write_mask_q) else $error("global");
   a_read_access: assert property (take && !(wr && |ln) |=> access_q == ACC_READ && bit_write_mask_q == '0) else $error("read");
   a_proc_ignored: assert property (!processor_addr_strobe_n && chip_select_first_n |=> !capture_q) else $error("ignore");
   a_proc_wins: assert property (take && !processor_addr_strobe_n |=> access_q == ACC_READ) else $error("proc");
   c_byte_write: cover property (wr && all_lanes_write_n && !lane_write_enable_n);
   c_proc_start: cover property (take && !processor_addr_strobe_n);
   c_deselect: cover property (!sel && !controller_addr_strobe_n);
endmodule
bind sync_sram_addr_write_capture sram_cap_asserts chk_i (.*);
`default_nettype wire

// ### verification/write_ctl_master.sv
`timescale 1ns/1ps
`default_nettype none
module write_ctl_master
(
   input  wire logic       glob,
   input  wire logic       byte_wr,
   input  wire logic [3:0] lanes,
   output logic            all_lanes_write_n,
   output logic            lane_write_enable_n,
   output logic [3:0]      lane_write_sel_n
);
   assign all_lanes_write_n = !glob;
   assign lane_write_enable_n = !byte_wr;
   assign lane_write_sel_n = ~lanes;
endmodule
`default_nettype wire

// ### verification/sync_sram_addr_write_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_sram_addr_write_capture_tb;
   import sram_capture_pkg::*;
   logic mclk, resetn, glob, byte_wr, lane_write_enable_n, all_lanes_write_n, capture_q;
   logic processor_addr_strobe_n, controller_addr_strobe_n, chip_select_first_n, chip_select_second, chip_select_third_n;
   logic [3:0] lanes, lane_write_sel_n;
   logic [ADDR_W-1:0] addr_in, addr_q, last_addr;
   logic [BURST_W-1:0] burst_count_q;
   logic [1:0] access_q;
   logic [35:0] wr_data_in, bit_write_mask_q, wr_data_q;
   int failures, num_checks, cycles;
   // ****
   // rows: {proc, ctrl, sel1, sel2, sel3, glob, byte, lanes} -> {capture, access, lanes}
   // ****
   logic [10:0] row_in [13] = '{11'h4a0, 11'h495, 11'h48a, 11'h4b1, 11'h2a0, 11'h0a0, 11'h1a0,
                               11'h420, 11'h4e0, 11'h6a0, 11'h49f, 11'h498, 11'h490};
   logic [6:0] row_exp [13] = '{7'h6f, 7'h65, 7'h50, 7'h6f, 7'h50, 7'h50, 7'h00,
                               7'h00, 7'h00, 7'h00, 7'h6f, 7'h68, 7'h50};
   sync_sram_addr_write_capture uut (.*);
   write_ctl_master partner (.*);
   task automatic chk(input bit ok, input string msg);
      num_checks++;
      if (!ok)
      begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic drive(input logic [10:0] r, input logic [3:0] i);
      {processor_addr_strobe_n, controller_addr_strobe_n, chip_select_first_n, chip_select_second,
       chip_select_third_n, glob, byte_wr, lanes} = r;
      addr_in = {16'h5a5a, i};
      wr_data_in = {i, 32'h89abcdef};
   endtask
   function automatic logic [35:0] expand(input logic [3:0] l);
      return {{9{l[3]}}, {9{l[2]}}, {9{l[1]}}, {9{l[0]}}};
   endfunction
   initial
   begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
      if (++cycles > 100)
      begin
         failures++;
         close_out();
      end
   initial
   begin
      resetn = 0;
      drive(11'h6a0, 4'h0);
      last_addr = '0;
      repeat (2) @(posedge mclk);
      #1 resetn = 1;
      // back to back rows, so a flag that fails to drop shows on the next row
      for (int i = 0; i < 13; i++)
      begin
         drive(row_in[i], i[3:0]);
         @(posedge mclk);
         #1;
         if (row_exp[i][6]) last_addr = addr_in;
         chk(capture_q === row_exp[i][6] && addr_q === last_addr, "capture");
         chk(burst_count_q === last_addr[1:0], "burst");
         chk(access_q === row_exp[i][5:4] && bit_write_mask_q === expand(row_exp[i][3:0]), "lanes");
         chk(wr_data_q === wr_data_in, "data");
      end
      // async reset in mid-run clears a fresh capture at once
      drive(row_in[0], 4'h7);
      @(posedge mclk);
      #1 resetn = 0;
      #1 chk({addr_q, burst_count_q, capture_q, access_q, bit_write_mask_q, wr_data_q} === '0, "reset");
      // second release: the first edge after it already takes a request
      @(posedge mclk);
      #1 resetn = 1;
      drive(row_in[1], 4'h6);
      @(posedge mclk);
      #1 chk(capture_q === 1'h1 && addr_q === {16'h5a5a, 4'h6} && burst_count_q === 2'h2, "release");
      chk(access_q === row_exp[1][5:4] && bit_write_mask_q === expand(row_exp[1][3:0]), "release lanes");
      close_out();
   end
endmodule
`default_nettype wire
